// ---- hdl/fcb_load_timer.sv ----
`timescale 1ns/1ps
`include "fcb_params.svh"
module fcb_load_timer #(
  parameter int SHORT_CYC = `FCB_LOAD_SHORT_CYC,
  parameter int LONG_CYC  = `FCB_LOAD_LONG_CYC
) (
  // Clock and reset.
  input  wire logic clock_in,
  input  wire logic reset_in,
  // Control.
  input  wire logic start_in,
  input  wire logic long_in,
  input  wire logic stop_in,
  // One-cycle pulse when the load time has run out.
  output logic      done_out
);
  logic [`FCB_TIMER_W-1:0] cnt_ff;   // Cycles still to run.
  logic                    run_ff;   // Counting.
  logic [`FCB_TIMER_W-1:0] nxt_cnt;
  logic                    nxt_run;
  logic                    nxt_done;

  // Load the chosen length, count down, pulse at zero; stop wins.
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_run  = run_ff;
    nxt_done = 1'b0;
    if (stop_in) begin
      nxt_run = 1'b0;
    end else if (start_in) begin
      nxt_run = 1'b1;
      nxt_cnt = long_in ? `FCB_TIMER_W'(LONG_CYC - 1) : `FCB_TIMER_W'(SHORT_CYC - 1);
    end else if (run_ff) begin
      if (cnt_ff == '0) begin
        nxt_run  = 1'b0;
        nxt_done = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - `FCB_TIMER_W'(1);
      end
    end
  end

  // Register the counter state.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      cnt_ff   <= '0;
      run_ff   <= 1'b0;
      done_out <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      run_ff   <= nxt_run;
      done_out <= nxt_done;
    end
  end
endmodule

// ---- hdl/fcb_params.svh ----
`ifndef FCB_PARAMS_SVH
`define FCB_PARAMS_SVH
// Opcodes taken from the serial link.
`define FCB_OP_LOCK       8'h6F
`define FCB_LOCK_KEY1     8'h4D
`define FCB_LOCK_KEY2     8'h67
`define FCB_OP_BATTERY    8'hEF
`define FCB_OP_SUSPEND    8'h75
`define FCB_OP_RESUME     8'h7A
`define FCB_OP_ABORT      8'hF0
`define FCB_OP_RD_CFG     8'h2B
`define FCB_OP_WR_CFG     8'h2C
`define FCB_OP_RD_BAT     8'h2D
`define FCB_OP_WR_BAT     8'h2E
// Power-up values of both register bytes.
`define FCB_CFG_RESET     8'h00
`define FCB_BAT_RESET     8'h00
// Battery result codes.
`define FCB_RES_IDLE      2'h0
`define FCB_RES_RUN       2'h1
`define FCB_RES_ABOVE     2'h2
`define FCB_RES_BELOW     2'h3
// Load time, in nanoseconds, and the derived cycle counts (rounded up).
`define FCB_CLK_PERIOD_NS 50
`define FCB_LOAD_SHORT_NS 100000
`define FCB_LOAD_LONG_NS  1000000
`define FCB_LOAD_SHORT_CYC ((`FCB_LOAD_SHORT_NS + `FCB_CLK_PERIOD_NS - 1) / `FCB_CLK_PERIOD_NS)
`define FCB_LOAD_LONG_CYC  ((`FCB_LOAD_LONG_NS + `FCB_CLK_PERIOD_NS - 1) / `FCB_CLK_PERIOD_NS)
`define FCB_TIMER_W       20
`endif

// ---- hdl/fcb_pkg.sv ----
package fcb_pkg;
  // Lock, dummy-clock, suspend and option byte, bit 7 first.
  typedef struct packed {
    logic       config_lock_flag;
    logic [2:0] dummy_cycle_count;
    logic       erase_paused_flag;
    logic       program_halted_flag;
    logic       abort_command_allow;
    logic       word_aligned_addressing;
  } fcb_cfg_t;
  // Battery monitor byte, bit 7 first.
  typedef struct packed {
    logic [1:0] battery_test_result;
    logic [2:0] battery_threshold;
    logic [1:0] battery_load_select;
    logic       battery_load_duration;
  } fcb_bat_t;
  // Commands passed from the link domain to the register domain.
  typedef enum logic [2:0] {EV_LOCK, EV_WR_CFG, EV_WR_BAT, EV_BATTERY, EV_SUSPEND, EV_RESUME, EV_ABORT} fcb_evt_kind_t;
  typedef struct packed {
    fcb_evt_kind_t kind;
    logic [7:0]    data;
  } fcb_evt_t;
  // Link decoder states and battery test states.
  typedef enum logic [2:0] {LS_OPCODE, LS_KEY1, LS_KEY2, LS_DATA, LS_READ, LS_IGNORE} fcb_link_state_t;
  typedef enum logic {BS_IDLE, BS_LOAD} fcb_bat_state_t;
endpackage

// ---- hdl/fcb_regs.sv ----
`timescale 1ns/1ps
`include "fcb_params.svh"
module fcb_regs
  import fcb_pkg::*;
#(
  parameter int LOAD_SHORT_CYC = `FCB_LOAD_SHORT_CYC,
  parameter int LOAD_LONG_CYC  = `FCB_LOAD_LONG_CYC
) (
  // Register clock and reset.
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  // Serial link, clocked by the host.
  input  wire logic        spi_clk_in,
  input  wire logic        spi_cs_n_in,
  input  wire logic        spi_mosi_in,
  output logic             spi_miso_out,
  output logic             spi_miso_en_n_out,
  // Flash core status, same clock.
  input  wire logic        erase_active_in,
  input  wire logic        program_active_in,
  // Battery comparator, asynchronous; high when below threshold.
  input  wire logic        battery_below_in,
  // Quad read address path.
  input  wire logic        aligned_read_in,
  input  wire logic [23:0] read_addr_in,
  output logic      [23:0] read_addr_out,
  // Register contents and derived controls.
  output fcb_cfg_t         cfg_reg_out,
  output fcb_bat_t         bat_reg_out,
  output logic      [3:0]  dummy_clocks_out,
  output logic             abort_out,
  output logic             battery_load_on_out
);

  // Maps the dummy-clock code to a clock count.
  function automatic logic [3:0] dc_to_clocks(input logic [2:0] code);
    logic [3:0] clocks;
    unique case (code)
      3'h0:    clocks = 4'h2;
      3'h1:    clocks = 4'h4;
      3'h2:    clocks = 4'h6;
      3'h3:    clocks = 4'h8;
      3'h4:    clocks = 4'hA;
      default: clocks = 4'h2; // Reserved codes behave as the power-up code.
    endcase
    return clocks;
  endfunction

  // ---------------- Link domain ----------------
  fcb_link_state_t state_ff;     // Decoder state within a frame.
  fcb_link_state_t nxt_state;
  logic [2:0]      bit_cnt_ff;   // Bit position in the current byte.
  logic [2:0]      nxt_bit_cnt;
  logic [6:0]      shift_ff;     // Bits received so far.
  logic [6:0]      nxt_shift;
  logic [7:0]      tx_ff;        // Outgoing byte, bit 7 next.
  logic [7:0]      nxt_tx;
  logic            sel_bat_ff;   // Frame addresses the battery byte.
  logic            nxt_sel_bat;
  logic            rd_on_ff;     // Frame is a register read.
  logic            nxt_rd_on;
  logic [7:0]      rx_byte;      // Byte completed on this edge.
  logic            post;         // A command is complete.
  fcb_evt_t        post_evt;     // The command completed.
  fcb_evt_t        evt_ff;       // Last command, held for the other domain.
  logic            evt_tgl_ff;   // Flips once per posted command.
  logic            nxt_miso;
  logic            nxt_miso_en_n;
  // Mirrors of the register bytes, frozen while a frame is open.
  fcb_cfg_t        mirror_cfg_ff;
  fcb_bat_t        mirror_bat_ff;

  // Decodes each byte as its last bit arrives.
  always_comb begin
    rx_byte     = {shift_ff, spi_mosi_in};
    nxt_bit_cnt = bit_cnt_ff + 3'h1;
    nxt_shift   = rx_byte[6:0];
    nxt_state   = state_ff;
    nxt_tx      = {tx_ff[6:0], 1'b0};
    nxt_sel_bat = sel_bat_ff;
    nxt_rd_on   = rd_on_ff;
    post        = 1'b0;
    post_evt    = evt_ff;
    if (bit_cnt_ff == 3'h7) begin
      nxt_state = LS_IGNORE;
      unique case (state_ff)
        LS_OPCODE: begin
          // Opcodes that carry no data post at once.
          unique case (rx_byte)
            `FCB_OP_LOCK: begin
              nxt_state = LS_KEY1;
            end
            `FCB_OP_WR_CFG, `FCB_OP_WR_BAT: begin
              nxt_state   = LS_DATA;
              nxt_sel_bat = (rx_byte == `FCB_OP_WR_BAT);
            end
            `FCB_OP_RD_CFG: begin
              nxt_state   = LS_READ;
              nxt_sel_bat = 1'b0;
              nxt_rd_on   = 1'b1;
              nxt_tx      = mirror_cfg_ff;
            end
            `FCB_OP_RD_BAT: begin
              nxt_state   = LS_READ;
              nxt_sel_bat = 1'b1;
              nxt_rd_on   = 1'b1;
              nxt_tx      = mirror_bat_ff;
            end
            `FCB_OP_BATTERY: begin
              post          = 1'b1;
              post_evt.kind = EV_BATTERY;
            end
            `FCB_OP_SUSPEND: begin
              post          = 1'b1;
              post_evt.kind = EV_SUSPEND;
            end
            `FCB_OP_RESUME: begin
              post          = 1'b1;
              post_evt.kind = EV_RESUME;
            end
            `FCB_OP_ABORT: begin
              post          = 1'b1;
              post_evt.kind = EV_ABORT;
            end
            default: begin
              nxt_state = LS_IGNORE;             // Unknown opcode: ignore the frame.
            end
          endcase
        end
        LS_KEY1: begin
          if (rx_byte == `FCB_LOCK_KEY1) begin
            nxt_state = LS_KEY2;
          end
        end
        LS_KEY2: begin
          if (rx_byte == `FCB_LOCK_KEY2) begin
            post          = 1'b1;
            post_evt.kind = EV_LOCK;
          end
        end
        LS_DATA: begin
          post          = 1'b1;
          post_evt.kind = sel_bat_ff ? EV_WR_BAT : EV_WR_CFG;
          post_evt.data = rx_byte;
        end
        LS_READ: begin
          // Repeat the same byte while the host keeps clocking.
          nxt_state = LS_READ;
          nxt_tx    = sel_bat_ff ? mirror_bat_ff : mirror_cfg_ff;
        end
        LS_IGNORE: begin
          nxt_state = LS_IGNORE;
        end
      endcase
    end
  end

  // Frame state clears while select is high, so each frame starts clean.
  always_ff @(posedge spi_clk_in or posedge spi_cs_n_in) begin
    if (spi_cs_n_in) begin
      state_ff   <= LS_OPCODE;
      bit_cnt_ff <= 3'h0;
      shift_ff   <= 7'h00;
      tx_ff      <= 8'h00;
      sel_bat_ff <= 1'b0;
      rd_on_ff   <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff   <= nxt_shift;
      tx_ff      <= nxt_tx;
      sel_bat_ff <= nxt_sel_bat;
      rd_on_ff   <= nxt_rd_on;
    end
  end

  // Posted command and its toggle outlive the frame.
  always_ff @(posedge spi_clk_in or posedge reset_in) begin
    if (reset_in) begin
      evt_ff     <= '0;
      evt_tgl_ff <= 1'b0;
    end else begin
      evt_ff     <= post ? post_evt : evt_ff;
      evt_tgl_ff <= evt_tgl_ff ^ post;
    end
  end

  // Output data changes on the falling edge, MSB first.
  always_comb begin
    nxt_miso      = rd_on_ff & tx_ff[7];
    nxt_miso_en_n = ~rd_on_ff;
  end

  // Output pin register; released whenever select is high.
  always_ff @(negedge spi_clk_in or posedge spi_cs_n_in) begin
    if (spi_cs_n_in) begin
      spi_miso_out      <= 1'b0;
      spi_miso_en_n_out <= 1'b1;
    end else begin
      spi_miso_out      <= nxt_miso;
      spi_miso_en_n_out <= nxt_miso_en_n;
    end
  end

  // ---------------- Register domain ----------------
  logic [2:0]     sync_vec;      // Settled select, comparator and toggle.
  logic           cs_idle;       // No frame open.
  logic           below;         // Battery below threshold.
  logic           tgl_seen_ff;   // Toggle value already handled.
  logic           new_evt;       // A fresh command is waiting.
  fcb_bat_state_t bstate_ff;     // Battery test state.
  fcb_bat_state_t nxt_bstate;
  fcb_cfg_t       nxt_cfg;
  fcb_bat_t       nxt_bat;
  logic           nxt_abort;
  logic           timer_start;
  logic           timer_stop;
  logic           timer_done;

  // Select, comparator and command toggle come from other clocks.
  fcb_sync #(.W(3), .RST(3'h4)) u_sync (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .async_in ({spi_cs_n_in, battery_below_in, evt_tgl_ff}),
    .sync_out (sync_vec)
  );

  assign cs_idle = sync_vec[2];
  assign below   = sync_vec[1];
  assign new_evt = sync_vec[0] ^ tgl_seen_ff;

  // Times the load applied to the battery.
  fcb_load_timer #(.SHORT_CYC(LOAD_SHORT_CYC), .LONG_CYC(LOAD_LONG_CYC)) u_timer (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .start_in (timer_start),
    .long_in  (bat_reg_out.battery_load_duration),
    .stop_in  (timer_stop),
    .done_out (timer_done)
  );

  // Applies commands and hardware events to both register bytes.
  always_comb begin
    nxt_cfg     = cfg_reg_out;
    nxt_bat     = bat_reg_out;
    nxt_bstate  = bstate_ff;
    nxt_abort   = 1'b0;
    timer_start = 1'b0;
    timer_stop  = 1'b0;
    // Load time over: compare and record the outcome.
    if (timer_done && bstate_ff == BS_LOAD) begin
      nxt_bat.battery_test_result = below ? `FCB_RES_BELOW : `FCB_RES_ABOVE;
      nxt_bstate                  = BS_IDLE;
    end
    if (new_evt) begin
      unique case (evt_ff.kind)
        EV_LOCK: begin
          nxt_cfg.config_lock_flag = 1'b1;
        end
        EV_WR_CFG: begin
          // Only writable fields change; refused once locked.
          if (!cfg_reg_out.config_lock_flag) begin
            nxt_cfg.dummy_cycle_count       = evt_ff.data[6:4];
            nxt_cfg.abort_command_allow     = evt_ff.data[1];
            nxt_cfg.word_aligned_addressing = evt_ff.data[0];
          end
        end
        EV_WR_BAT: begin
          if (!cfg_reg_out.config_lock_flag) begin
            nxt_bat.battery_threshold     = evt_ff.data[5:3];
            nxt_bat.battery_load_select   = evt_ff.data[2:1];
            nxt_bat.battery_load_duration = evt_ff.data[0];
          end
        end
        EV_BATTERY: begin
          // A test already running is not restarted.
          if (bstate_ff == BS_IDLE) begin
            nxt_bat.battery_test_result = `FCB_RES_RUN;
            nxt_bstate                  = BS_LOAD;
            timer_start                 = 1'b1;
          end
        end
        EV_SUSPEND: begin
          if (erase_active_in) begin
            nxt_cfg.erase_paused_flag = 1'b1;
          end else if (program_active_in) begin
            nxt_cfg.program_halted_flag = 1'b1;
          end
        end
        EV_RESUME: begin
          nxt_cfg.erase_paused_flag   = 1'b0;
          nxt_cfg.program_halted_flag = 1'b0;
        end
        EV_ABORT: begin
          // Ignored while the enable is clear.
          if (cfg_reg_out.abort_command_allow) begin
            nxt_abort                   = 1'b1;
            nxt_cfg.erase_paused_flag   = 1'b0;
            nxt_cfg.program_halted_flag = 1'b0;
            nxt_bat.battery_test_result = `FCB_RES_IDLE;
            nxt_bstate                  = BS_IDLE;
            timer_stop                  = 1'b1;
          end
        end
        default: begin
          nxt_cfg = cfg_reg_out;
        end
      endcase
    end
  end

  // Register bytes, test state and derived outputs.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      cfg_reg_out         <= `FCB_CFG_RESET;
      bat_reg_out         <= `FCB_BAT_RESET;
      bstate_ff           <= BS_IDLE;
      tgl_seen_ff         <= 1'b0;
      abort_out           <= 1'b0;
      battery_load_on_out <= 1'b0;
      dummy_clocks_out    <= 4'h2;
      read_addr_out       <= 24'h000000;
      mirror_cfg_ff       <= `FCB_CFG_RESET;
      mirror_bat_ff       <= `FCB_BAT_RESET;
    end else begin
      cfg_reg_out         <= nxt_cfg;
      bat_reg_out         <= nxt_bat;
      bstate_ff           <= nxt_bstate;
      tgl_seen_ff         <= sync_vec[0];
      abort_out           <= nxt_abort;
      battery_load_on_out <= (nxt_bstate == BS_LOAD);
      // The count already holds the two mode-bit clocks.
      dummy_clocks_out    <= dc_to_clocks(nxt_cfg.dummy_cycle_count);
      // Low address bits cleared only for the aligned read.
      read_addr_out       <= (aligned_read_in && cfg_reg_out.word_aligned_addressing) ?
                             {read_addr_in[23:2], 2'h0} : read_addr_in;
      // Mirrors follow only between frames so link reads stay stable.
      if (cs_idle && !new_evt) begin
        mirror_cfg_ff <= cfg_reg_out;
        mirror_bat_ff <= bat_reg_out;
      end
    end
  end
endmodule

// ---- hdl/fcb_sync.sv ----
`timescale 1ns/1ps
module fcb_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset.
  input  wire logic         clock_in,
  input  wire logic         reset_in,
  // Foreign level and its settled copy.
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1_ff;    // First stage, read only by the second.
  logic [W-1:0] s2_ff;    // Second stage.
  logic [W-1:0] s3_ff;    // Third stage.
  logic [W-1:0] nxt_sync; // Settled value.

  // A bit changes only once the second and third stages agree.
  always_comb begin
    nxt_sync = (s3_ff & ~(s2_ff ^ s3_ff)) | (sync_out & (s2_ff ^ s3_ff));
  end

  // The stages shift on every rising edge outside reset.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      s1_ff    <= RST;
      s2_ff    <= RST;
      s3_ff    <= RST;
      sync_out <= RST;
    end else begin
      s1_ff    <= async_in;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      sync_out <= nxt_sync;
    end
  end
endmodule

// ---- tb/fcb_checker.sv ----
`timescale 1ns/1ps
module fcb_checker
  import fcb_pkg::*;
#(
  parameter int LOAD_SHORT_CYC = 2000,
  parameter int LOAD_LONG_CYC  = 20000
) (
  // Clock and reset.
  input wire logic        clock_in,
  input wire logic        reset_in,
  // Link and address path.
  input wire logic        spi_cs_n_in,
  input wire logic        spi_miso_en_n_out,
  input wire logic        aligned_read_in,
  input wire logic [23:0] read_addr_in,
  input wire logic [23:0] read_addr_out,
  // Register contents and controls.
  input wire fcb_cfg_t    cfg_reg_out,
  input wire fcb_bat_t    bat_reg_out,
  input wire logic [3:0]  dummy_clocks_out,
  input wire logic        abort_out,
  input wire logic        battery_load_on_out
);
  logic [20:0] load_cnt_ff;  // Cycles the load has been on.
  logic [20:0] nxt_load_cnt; // Next value of that count.
  // Maps a dummy code to its clock count; reserved codes fall back to two.
  function automatic logic [3:0] dclk(input logic [2:0] c);
    return (c <= 3'h4) ? {c, 1'b0} + 4'h2 : 4'h2;
  endfunction
  // The count restarts whenever the load is off.
  always_comb begin
    nxt_load_cnt = battery_load_on_out ? load_cnt_ff + 21'h1 : 21'h0;
  end
  // Registers the count.
  always_ff @(posedge clock_in) begin
    load_cnt_ff <= reset_in ? 21'h0 : nxt_load_cnt;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  property p_addr_align;
    aligned_read_in && cfg_reg_out.word_aligned_addressing |=> read_addr_out == ($past(read_addr_in) & 24'hFFFFFC);
  endproperty
  a_addr_align: assert property (p_addr_align) else $error("aligned address keeps low bits");
  property p_addr_pass;
    !aligned_read_in |=> read_addr_out == $past(read_addr_in);
  endproperty
  a_addr_pass: assert property (p_addr_pass) else $error("plain read address altered");
  property p_dummy;
    $stable(cfg_reg_out) [*2] |-> dummy_clocks_out == dclk(cfg_reg_out.dummy_cycle_count);
  endproperty
  a_dummy: assert property (p_dummy) else $error("dummy clock count wrong");
  property p_abort_en;
    abort_out |-> cfg_reg_out.abort_command_allow;
  endproperty
  a_abort_en: assert property (p_abort_en) else $error("abort taken while disabled");
  property p_abort_clr;
    abort_out |-> ##[0:1] !cfg_reg_out.erase_paused_flag && !cfg_reg_out.program_halted_flag && !battery_load_on_out;
  endproperty
  a_abort_clr: assert property (p_abort_clr) else $error("abort left state behind");
  property p_run;
    $rose(battery_load_on_out) |-> bat_reg_out.battery_test_result == 2'h1;
  endproperty
  a_run: assert property (p_run) else $error("running test not reported");
  property p_load_len;
    $fell(battery_load_on_out) && bat_reg_out.battery_test_result[1] |->
      load_cnt_ff >= (bat_reg_out.battery_load_duration ? LOAD_LONG_CYC : LOAD_SHORT_CYC) &&
      load_cnt_ff <= (bat_reg_out.battery_load_duration ? LOAD_LONG_CYC : LOAD_SHORT_CYC) + 2;
  endproperty
  a_load_len: assert property (p_load_len) else $error("load time wrong");
  property p_miso_idle;
    spi_cs_n_in && $past(spi_cs_n_in) |-> spi_miso_en_n_out;
  endproperty
  a_miso_idle: assert property (p_miso_idle) else $error("data line driven outside frame");
  property p_lock_stick;
    !$fell(cfg_reg_out.config_lock_flag);
  endproperty
  a_lock_stick: assert property (p_lock_stick) else $error("lock flag cleared");
  property p_lock_refuse;
    cfg_reg_out.config_lock_flag && !$rose(cfg_reg_out.config_lock_flag) |->
      $stable({cfg_reg_out[6:4], cfg_reg_out[1:0], bat_reg_out[5:0]});
  endproperty
  a_lock_refuse: assert property (p_lock_refuse) else $error("locked register changed");
endmodule

bind fcb_regs fcb_checker #(.LOAD_SHORT_CYC(LOAD_SHORT_CYC), .LOAD_LONG_CYC(LOAD_LONG_CYC)) fcb_checker_i (
  .clock_in(clock_in), .reset_in(reset_in), .spi_cs_n_in(spi_cs_n_in), .spi_miso_en_n_out(spi_miso_en_n_out),
  .aligned_read_in(aligned_read_in), .read_addr_in(read_addr_in), .read_addr_out(read_addr_out),
  .cfg_reg_out(cfg_reg_out), .bat_reg_out(bat_reg_out), .dummy_clocks_out(dummy_clocks_out),
  .abort_out(abort_out), .battery_load_on_out(battery_load_on_out));

// ---- tb/fcb_host.sv ----
`timescale 1ns/1ps
module fcb_host (
  // Serial link toward the device.
  output logic      spi_clk_out,
  output logic      spi_cs_n_out,
  output logic      spi_mosi_out,
  // Data returned by the device.
  input  wire logic spi_miso_in
);
  // The link clock stands still; select starts low, then stays high until a command is sent.
  initial begin
    spi_clk_out  = 1'b0;
    spi_cs_n_out = 1'b0;
    spi_mosi_out = 1'b0;
    // A rising select just after time zero clears the device's frame state.
    #1 spi_cs_n_out = 1'b1;
  end
  // Sends n bytes in one frame; rd keeps the last eight bits seen coming back.
  task automatic frame(input logic [23:0] bits, input int n, output logic [7:0] rd);
    rd = 8'h00;
    spi_cs_n_out = 1'b0;
    #200;
    for (int i = n * 8 - 1; i >= 0; i--) begin
      spi_mosi_out = bits[i];
      #7.5 spi_clk_out = 1'b1;
      rd = {rd[6:0], spi_miso_in};
      #7.5 spi_clk_out = 1'b0;
    end
    #7.5 spi_cs_n_out = 1'b1;
    spi_mosi_out = ~spi_mosi_out; // A released line must not look like held data.
  endtask
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`include "fcb_params.svh"
module testbench;
  import fcb_pkg::*;
  localparam int SHORT = 20; // Shortened load times keep the run brief.
  localparam int LONG  = 50;
  logic        clock_in  = 1'b0;
  logic        reset_in;  // Raised just after time zero so the link-side reset sees a rising edge.
  logic        spi_clk;
  logic        spi_cs_n;
  logic        spi_mosi;
  logic        spi_miso;
  logic        spi_miso_en_n;
  logic        erase_act = 1'b0;
  logic        prog_act  = 1'b0;
  logic        below     = 1'b0;
  logic        aligned   = 1'b0;
  logic [23:0] addr      = 24'h000000;
  logic [23:0] addr_q;
  fcb_cfg_t    cfg;
  fcb_bat_t    bat;
  logic [3:0]  dummy;
  logic        abort;
  logic        load_on;
  fcb_cfg_t    exp_cfg   = '0; // Expected register contents.
  fcb_bat_t    exp_bat   = '0;
  logic [7:0]  rd;
  logic [7:0]  d;
  int          error_cnt = 0;
  int          checked   = 0;
  int          aborts    = 0; // Abort pulses seen.
  int          n;
  // Register clock at 20 MHz.
  always #25 clock_in = ~clock_in;
  // Counts accepted aborts.
  always @(negedge clock_in) if (abort === 1'b1) aborts++;
  // A released data line floats high through its pull-up.
  fcb_host fcb_host_i (.spi_clk_out(spi_clk), .spi_cs_n_out(spi_cs_n), .spi_mosi_out(spi_mosi),
                       .spi_miso_in(spi_miso_en_n ? 1'b1 : spi_miso));
  fcb_regs #(.LOAD_SHORT_CYC(SHORT), .LOAD_LONG_CYC(LONG)) fcb_regs_i (
    .clock_in(clock_in), .reset_in(reset_in), .spi_clk_in(spi_clk), .spi_cs_n_in(spi_cs_n),
    .spi_mosi_in(spi_mosi), .spi_miso_out(spi_miso), .spi_miso_en_n_out(spi_miso_en_n),
    .erase_active_in(erase_act), .program_active_in(prog_act), .battery_below_in(below),
    .aligned_read_in(aligned), .read_addr_in(addr), .read_addr_out(addr_q), .cfg_reg_out(cfg),
    .bat_reg_out(bat), .dummy_clocks_out(dummy), .abort_out(abort), .battery_load_on_out(load_on));
  // Dummy clocks expected for a code.
  function automatic logic [3:0] dclk(input logic [2:0] c);
    return (c <= 3'h4) ? {c, 1'b0} + 4'h2 : 4'h2;
  endfunction
  // Compares and counts.
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One frame, then enough idle time for the effect to land.
  task automatic cmd(input logic [23:0] b, input int nb);
    fcb_host_i.frame(b, nb, rd);
    repeat (12) @(negedge clock_in);
  endtask
  // Writes; read-only bits and locked registers keep their values.
  task automatic wr_cfg(input logic [7:0] v);
    cmd({8'h00, `FCB_OP_WR_CFG, v}, 2);
    if (!exp_cfg.config_lock_flag) {exp_cfg.dummy_cycle_count, exp_cfg[1:0]} = {v[6:4], v[1:0]};
  endtask
  task automatic wr_bat(input logic [7:0] v);
    cmd({8'h00, `FCB_OP_WR_BAT, v}, 2);
    if (!exp_cfg.config_lock_flag) exp_bat[5:0] = v[5:0];
  endtask
  // Checks both bytes at the ports and over the link.
  task automatic regs_ok;
    check("cfg", 24'(cfg), 24'(exp_cfg));
    check("bat", 24'(bat), 24'(exp_bat));
    check("dummy", 24'(dummy), 24'(dclk(exp_cfg.dummy_cycle_count)));
    cmd({8'h00, `FCB_OP_RD_CFG, 8'h00}, 2);
    check("cfg read", 24'(rd), 24'(exp_cfg));
    cmd({8'h00, `FCB_OP_RD_BAT, 8'h00}, 2);
    check("bat read", 24'(rd), 24'(exp_bat));
  endtask
  initial begin
    void'($urandom(15197));
    #1 reset_in = 1'b1;
    repeat (3) @(negedge clock_in);
    reset_in = 1'b0;
    repeat (4) @(negedge clock_in);
    regs_ok();
    check("miso enable", 24'(spi_miso_en_n), 24'h000001);
    $display("reset test done");
    for (int c = 0; c < 8; c++) begin
      wr_cfg({1'b1, 3'(c), 2'b11, 2'($urandom)});
      wr_bat({2'b11, 3'(c), 2'(c), 1'($urandom)});
      regs_ok();
    end
    $display("write and dummy clock test done");
    for (int i = 0; i < 8; i++) begin
      if (i % 4 == 0) wr_cfg(8'(i / 4));
      aligned = 1'($urandom);
      addr = 24'($urandom);
      @(negedge clock_in);
      check("address", addr_q, (aligned && exp_cfg.word_aligned_addressing) ? addr & 24'hFFFFFC : addr);
    end
    $display("address test done");
    wr_cfg(8'h00);
    erase_act = 1'b1;
    cmd({16'h0000, `FCB_OP_SUSPEND}, 1);
    exp_cfg.erase_paused_flag = 1'b1;
    check("erase suspend", 24'(cfg), 24'(exp_cfg));
    erase_act = 1'b0;
    cmd({16'h0000, `FCB_OP_RESUME}, 1);
    exp_cfg.erase_paused_flag = 1'b0;
    check("resume", 24'(cfg), 24'(exp_cfg));
    prog_act = 1'b1;
    cmd({16'h0000, `FCB_OP_SUSPEND}, 1);
    prog_act = 1'b0;
    exp_cfg.program_halted_flag = 1'b1;
    check("program suspend", 24'(cfg), 24'(exp_cfg));
    cmd({16'h0000, `FCB_OP_ABORT}, 1);
    check("abort refused", 24'(aborts), 24'h000000);
    wr_cfg(8'h02);
    cmd({16'h0000, `FCB_OP_ABORT}, 1);
    exp_cfg.program_halted_flag = 1'b0;
    check("abort taken", 24'(aborts), 24'h000001);
    regs_ok();
    $display("suspend and abort test done");
    for (int k = 0; k < 3; k++) begin
      wr_bat({2'b11, 5'($urandom), k != 0});
      below = 1'($urandom);
      fcb_host_i.frame({16'h0000, `FCB_OP_BATTERY}, 1, rd);
      repeat (10) @(negedge clock_in);
      check("load on", 24'(load_on), 24'h000001);
      check("result running", 24'(bat.battery_test_result), 24'(`FCB_RES_RUN));
      if (k == 2) begin
        cmd({16'h0000, `FCB_OP_ABORT}, 1);
        exp_bat.battery_test_result = `FCB_RES_IDLE;
      end else begin
        n = 10;
        while (load_on === 1'b1 && n < LONG + 40) begin
          @(negedge clock_in);
          n++;
        end
        if (n >= LONG + 40) begin
          error_cnt++;
          tally_and_finish();
        end
        d = (k == 0) ? 8'(SHORT) : 8'(LONG);
        check("load time", 24'(n >= d + 3 && n <= d + 9), 24'h000001);
        exp_bat.battery_test_result = below ? `FCB_RES_BELOW : `FCB_RES_ABOVE;
      end
      regs_ok();
    end
    $display("battery test done");
    cmd({`FCB_OP_LOCK, `FCB_LOCK_KEY1, 8'h66}, 3);
    regs_ok();
    cmd({`FCB_OP_LOCK, `FCB_LOCK_KEY1, `FCB_LOCK_KEY2}, 3);
    exp_cfg.config_lock_flag = 1'b1;
    wr_cfg(8'h7D);
    wr_bat(8'h3F);
    regs_ok();
    $display("lock test done");
    tally_and_finish();
  end
endmodule
